// >>> src/caqt_consts.svh
/*
 Offsets, field positions, reset values and timing counts of the
 calibration status, alarm control and answer timer register bank.
 Assumes inclusion by bare name from the design file, the host model and the bench.
*/
`ifndef CAQT_CONSTS_SVH
`define CAQT_CONSTS_SVH

// Write addresses; the read address is the write address with bit 7 set
`define CAQT_WA_CAL_CLR 8'h44
`define CAQT_WA_ALM_CTRL 8'h48
`define CAQT_WA_ANSWER_TIMER_CONTROL 8'h4C
`define CAQT_WA_ANSWER 8'h50
`define CAQT_RA_CAL_STAT 8'hC4
`define CAQT_RA_QA_COUNT 8'hD0
`define CAQT_RD_BIT 7

// Calibration flag positions (clear register and status register)
`define CAQT_B_PH_A 8
`define CAQT_B_PH_B 4
`define CAQT_B_PH_C 0
`define CAQT_B_CAL_ACT 12

// Alarm control fields
`define CAQT_B_ALM_RSP 12
`define CAQT_B_ALM_FIL 0

// Answer timer control fields and reset values
`define CAQT_B_QA_RSP 12
`define CAQT_B_QA_PER 8
`define CAQT_B_QA_EN 0
`define CAQT_RST_QA_RSP 3'h1
`define CAQT_RST_QA_PER 2'h0
`define CAQT_RST_PREV_EXP 4'hF

// Answer command field and codes
`define CAQT_B_CMD 4
`define CAQT_CMD_STOP 4'h5
`define CAQT_CMD_ANSWER 4'h7
`define CAQT_CMD_START 4'hA

// Answer timer error responses
`define CAQT_RSP_HOLD 3'h1
`define CAQT_RSP_ALL_OFF 3'h2
`define CAQT_RSP_MOTOR_OFF 3'h3
`define CAQT_RSP_PUMP_OFF 3'h4

// Time base: system clock and internal tick rate in MHz
`define CAQT_SYS_MHZ 50
`define CAQT_TICK_MHZ 4
// Alarm filter multipliers N; time is N*4+1 ticks
`define CAQT_FIL_N0 16
`define CAQT_FIL_N1 1000
`define CAQT_FIL_N2 2000
`define CAQT_FIL_N3 4000
`define CAQT_FIL_MUL 4
// One millisecond in microseconds for the timeout periods
`define CAQT_MS_US 1000
// Accumulated errors that trigger the error response
`define CAQT_ERR_LIMIT 4

`endif

// >>> src/caqt_pkg.sv
/*
 Types of the calibration status, alarm control and answer timer bank.
 Uses no numeric constants from caqt_consts.svh; sizes are written inline.
*/
package caqt_pkg;

	// Calibration completion report from the amplifier sequencer
	typedef struct packed {
		logic running;
		logic done;
		logic pass;
		logic [2:0] phase;
	} caqt_cal_evt_t;

	// Gate driver shutdown requests
	typedef struct packed {
		logic all_off;
		logic motor_off;
		logic pump_off;
	} caqt_gate_t;

	// Answer timer sequence state, one-hot
	typedef enum logic [1:0] {
		QA_IDLE = 2'b01,
		QA_RUN = 2'b10
	} caqt_qa_state_t;

endpackage : caqt_pkg

// >>> src/caqt_regs.sv
/*
 Calibration status, alarm response/filter and answer timer registers.
 Assumes a serial front end presents decoded 8-bit address, 16-bit data
 write and read strobes synchronous to CLK_SYS, one access per strobe.
*/
`timescale 1ns/1ps
`include "caqt_consts.svh"

// Behaviour
// (R1) Writing 1 to clear bits 8/4/0 clears phase A/B/C pass flag; 0 ignored.
// (R2) Clear bits are one-shot; nothing to write back.
// (R3) Status bit 12 reads 1 while amplifier calibration runs.
// (R4) Pass flags at 8/4/0 read 1 for pass, reset to 0.
// (R5) Passing completion of a phase sets its pass flag.
// (R6) Failing completion of a phase clears its pass flag.
// (R7) Alarm drives fault low; select bit turns nine or six FETs off.
// (R8) Two-bit filter picks N of 16/1000/2000/4000; time N*4+1 ticks.
// (R9) Three-bit error response picks hold, nine off, six off, pump off; code 4h sets all_off as well as pump_off.
// (R10) Control bit 0 enables timeout; [9:8] picks 1/2/4/8 ms.
// (R11) Undefined control codes leave their field unchanged.
// (R12) Control always writable; timer uses values captured at start.
// (R13) Command codes 5h stop, 7h answer, Ah start.
// (R14) Unassigned command code during a sequence counts an error.
// (R15) Host puts four-bit answer payload in bits 3:0 with the command.
// (R16) Error count, sequence number and previous expected value readable.
// (R17) Read address equals write address with bit 7 set.
// (R18) Enabled timeout without correct answer in period counts an error.
module caqt_regs #(
	parameter int FIL_N0 = `CAQT_FIL_N0,
	parameter int FIL_N1 = `CAQT_FIL_N1,
	parameter int FIL_N2 = `CAQT_FIL_N2,
	parameter int FIL_N3 = `CAQT_FIL_N3,
	parameter int MS_TICKS = `CAQT_MS_US * `CAQT_TICK_MHZ,
	parameter logic [3:0] ERR_LIMIT = 4'(`CAQT_ERR_LIMIT)
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET,
	// Register access
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	output logic REG_RVALID,
	// Calibration sequencer and alarm
	input caqt_pkg::caqt_cal_evt_t CAL_EVT,
	input wire logic ALARM_IN,
	// Fault and gate outputs
	output logic FAULT_N,
	output caqt_pkg::caqt_gate_t GATE_OFF
);

	localparam int CW = 15;
	localparam int ACC_W = 6;

	logic [ACC_W-1:0] tick_acc_ff;
	logic tick_ff;
	logic [2:0] pass_ff;
	logic alm_rsp_ff;
	logic [1:0] alm_fil_ff;
	logic [CW-1:0] alm_cnt_ff;
	logic alarm_ff;
	logic [2:0] qa_rsp_ff;
	logic [1:0] qa_per_ff;
	logic qa_en_ff;
	logic [2:0] run_rsp_ff;
	logic [1:0] run_per_ff;
	logic run_en_ff;
	caqt_pkg::caqt_qa_state_t qa_st_ff;
	logic [CW-1:0] qa_ms_ff;
	logic [3:0] qa_msn_ff;
	logic [3:0] err_ff;
	logic [3:0] seq_ff;
	logic [3:0] prev_exp_ff;
	logic qa_trip_ff;
	logic [15:0] rdata_ff;
	logic rvalid_ff;
	logic fault_n_ff;
	caqt_pkg::caqt_gate_t gate_ff;

	logic wr_cal_clr, wr_alm, wr_qa, wr_ans;
	logic [3:0] cmd;
	logic [3:0] expected;
	logic cmd_start, cmd_stop, cmd_ans, cmd_bad, ans_ok;
	logic timeout;
	logic [CW-1:0] fil_lim;
	logic [3:0] per_ms;
	logic [4:0] nxt_err;

	assign wr_cal_clr = REG_WR && REG_ADDR == `CAQT_WA_CAL_CLR;
	assign wr_alm = REG_WR && REG_ADDR == `CAQT_WA_ALM_CTRL;
	assign wr_qa = REG_WR && REG_ADDR == `CAQT_WA_ANSWER_TIMER_CONTROL;
	assign wr_ans = REG_WR && REG_ADDR == `CAQT_WA_ANSWER;
	// (R13) command decode
	assign cmd = REG_WDATA[`CAQT_B_CMD+:4];
	assign cmd_start = wr_ans && cmd == `CAQT_CMD_START;
	assign cmd_stop = wr_ans && cmd == `CAQT_CMD_STOP;
	assign cmd_ans = wr_ans && cmd == `CAQT_CMD_ANSWER;
	assign cmd_bad = wr_ans && !cmd_start && !cmd_stop && !cmd_ans;
	// Question stream: expected answer is the inverted sequence number
	assign expected = ~seq_ff;
	// (R15) payload compared from the low nibble
	assign ans_ok = cmd_ans && REG_WDATA[3:0] == expected;

	// 4 MHz tick from 50 MHz by a fractional accumulator; exact on average
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			tick_acc_ff <= '0;
			tick_ff <= 1'b0;
		end
		else if (tick_acc_ff + ACC_W'(`CAQT_TICK_MHZ) >=
			ACC_W'(`CAQT_SYS_MHZ))
		begin
			tick_acc_ff <= ACC_W'(tick_acc_ff + ACC_W'(`CAQT_TICK_MHZ)
				- ACC_W'(`CAQT_SYS_MHZ));
			tick_ff <= 1'b1;
		end
		else
		begin
			tick_acc_ff <= ACC_W'(tick_acc_ff + ACC_W'(`CAQT_TICK_MHZ));
			tick_ff <= 1'b0;
		end
	end

	// Calibration pass flags; a completion in the clear cycle wins
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			pass_ff <= 3'h0;
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				// (R5) (R6) completion result
				if (CAL_EVT.done && CAL_EVT.phase[i])
					pass_ff[i] <= CAL_EVT.pass;
				// (R1) (R2) one-shot clear
				else if (wr_cal_clr && REG_WDATA[4*i])
					pass_ff[i] <= 1'b0;
			end
		end
	end

	// Alarm control register; every code of both fields is defined
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			alm_rsp_ff <= 1'b0;
			alm_fil_ff <= 2'h0;
		end
		else if (wr_alm)
		begin
			alm_rsp_ff <= REG_WDATA[`CAQT_B_ALM_RSP];
			alm_fil_ff <= REG_WDATA[`CAQT_B_ALM_FIL+:2];
		end
	end

	// (R8) filter length in ticks
	always_comb
	begin
		unique case (alm_fil_ff)
			2'h0: fil_lim = CW'(FIL_N0 * `CAQT_FIL_MUL + 1);
			2'h1: fil_lim = CW'(FIL_N1 * `CAQT_FIL_MUL + 1);
			2'h2: fil_lim = CW'(FIL_N2 * `CAQT_FIL_MUL + 1);
			2'h3: fil_lim = CW'(FIL_N3 * `CAQT_FIL_MUL + 1);
		endcase
	end

	// Alarm must stand for the whole filter time; a drop restarts it
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			alm_cnt_ff <= '0;
			alarm_ff <= 1'b0;
		end
		else if (!ALARM_IN)
		begin
			alm_cnt_ff <= '0;
			alarm_ff <= 1'b0;
		end
		else if (tick_ff && !alarm_ff)
		begin
			alm_cnt_ff <= CW'(alm_cnt_ff + 1'b1);
			alarm_ff <= CW'(alm_cnt_ff + 1'b1) >= fil_lim;
		end
	end

	// (R9) (R10) (R11) control register, undefined response codes kept
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			qa_rsp_ff <= `CAQT_RST_QA_RSP;
			qa_per_ff <= `CAQT_RST_QA_PER;
			qa_en_ff <= 1'b0;
		end
		else if (wr_qa)
		begin
			if (REG_WDATA[`CAQT_B_QA_RSP+:3] >= `CAQT_RSP_HOLD &&
				REG_WDATA[`CAQT_B_QA_RSP+:3] <= `CAQT_RSP_PUMP_OFF)
				qa_rsp_ff <= REG_WDATA[`CAQT_B_QA_RSP+:3];
			qa_per_ff <= REG_WDATA[`CAQT_B_QA_PER+:2];
			qa_en_ff <= REG_WDATA[`CAQT_B_QA_EN];
		end
	end

	// (R12) working copy taken on start
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			run_rsp_ff <= `CAQT_RST_QA_RSP;
			run_per_ff <= `CAQT_RST_QA_PER;
			run_en_ff <= 1'b0;
		end
		else if (cmd_start)
		begin
			run_rsp_ff <= qa_rsp_ff;
			run_per_ff <= qa_per_ff;
			run_en_ff <= qa_en_ff;
		end
	end

	// (R10) period in milliseconds: 1, 2, 4, 8
	assign per_ms = 4'h1 << run_per_ff;
	// (R18) timeout when the last millisecond of the period closes
	assign timeout = qa_st_ff == caqt_pkg::QA_RUN && run_en_ff && tick_ff
		&& qa_ms_ff == CW'(MS_TICKS - 1) && qa_msn_ff == per_ms - 4'h1;

	// Sequence state and timeout clock
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			qa_st_ff <= caqt_pkg::QA_IDLE;
			qa_ms_ff <= '0;
			qa_msn_ff <= 4'h0;
		end
		else
		begin
			unique case (qa_st_ff)
				caqt_pkg::QA_IDLE:
					if (cmd_start)
						qa_st_ff <= caqt_pkg::QA_RUN;
				caqt_pkg::QA_RUN:
					if (cmd_stop)
						qa_st_ff <= caqt_pkg::QA_IDLE;
			endcase
			if (cmd_start || ans_ok || timeout)
			begin
				qa_ms_ff <= '0;
				qa_msn_ff <= 4'h0;
			end
			else if (tick_ff)
			begin
				if (qa_ms_ff == CW'(MS_TICKS - 1))
				begin
					qa_ms_ff <= '0;
					qa_msn_ff <= 4'(qa_msn_ff + 1'b1);
				end
				else
					qa_ms_ff <= CW'(qa_ms_ff + 1'b1);
			end
		end
	end

	// Errors: wrong answer, unassigned code, timeout; saturates at 15
	always_comb
	begin
		nxt_err = {1'b0, err_ff};
		if (qa_st_ff == caqt_pkg::QA_RUN)
			// (R14) (R18) error accumulation
			nxt_err = nxt_err + 5'(cmd_bad) + 5'(cmd_ans && !ans_ok)
				+ 5'(timeout);
		if (nxt_err > 5'h0F)
			nxt_err = 5'h0F;
	end

	// (R16) readable sequence progress; restart keeps the error count
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			err_ff <= 4'h0;
			seq_ff <= 4'h0;
			prev_exp_ff <= `CAQT_RST_PREV_EXP;
		end
		else
		begin
			err_ff <= nxt_err[3:0];
			if (cmd_start && qa_st_ff == caqt_pkg::QA_IDLE)
				seq_ff <= 4'h0;
			else if (ans_ok && qa_st_ff == caqt_pkg::QA_RUN)
			begin
				seq_ff <= 4'(seq_ff + 1'b1);
				prev_exp_ff <= expected;
			end
		end
	end

	// Error response is held until reset once the limit is reached
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			qa_trip_ff <= 1'b0;
		else if (err_ff >= ERR_LIMIT)
			qa_trip_ff <= 1'b1;
	end

	// (R7) (R9) fault and shutdown outputs
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			fault_n_ff <= 1'b1;
			gate_ff <= '0;
		end
		else
		begin
			fault_n_ff <= !(alarm_ff || qa_trip_ff);
			gate_ff.all_off <= (alarm_ff && !alm_rsp_ff) || (qa_trip_ff &&
				(run_rsp_ff == `CAQT_RSP_ALL_OFF ||
				run_rsp_ff == `CAQT_RSP_PUMP_OFF));
			gate_ff.motor_off <= (alarm_ff && alm_rsp_ff) ||
				(qa_trip_ff && run_rsp_ff == `CAQT_RSP_MOTOR_OFF);
			gate_ff.pump_off <= qa_trip_ff &&
				run_rsp_ff == `CAQT_RSP_PUMP_OFF;
		end
	end

	// (R17) read decode; (R3) (R4) status fields; unmapped reads zero
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			rdata_ff <= 16'h0000;
			rvalid_ff <= 1'b0;
		end
		else
		begin
			rvalid_ff <= REG_RD;
			rdata_ff <= 16'h0000;
			if (REG_RD)
			begin
				unique case (REG_ADDR)
					`CAQT_RA_CAL_STAT:
					begin
						rdata_ff[`CAQT_B_CAL_ACT] <= CAL_EVT.running;
						rdata_ff[`CAQT_B_PH_A] <= pass_ff[2];
						rdata_ff[`CAQT_B_PH_B] <= pass_ff[1];
						rdata_ff[`CAQT_B_PH_C] <= pass_ff[0];
					end
					`CAQT_WA_ALM_CTRL | 8'h80:
					begin
						rdata_ff[`CAQT_B_ALM_RSP] <= alm_rsp_ff;
						rdata_ff[`CAQT_B_ALM_FIL+:2] <= alm_fil_ff;
					end
					`CAQT_WA_ANSWER_TIMER_CONTROL | 8'h80:
					begin
						rdata_ff[`CAQT_B_QA_RSP+:3] <= qa_rsp_ff;
						rdata_ff[`CAQT_B_QA_PER+:2] <= qa_per_ff;
						rdata_ff[`CAQT_B_QA_EN] <= qa_en_ff;
					end
					`CAQT_RA_QA_COUNT:
						rdata_ff[11:0] <= {err_ff, seq_ff, prev_exp_ff};
					default:
						rdata_ff <= 16'h0000;
				endcase
			end
		end
	end

	assign REG_RDATA = rdata_ff;
	assign REG_RVALID = rvalid_ff;
	assign FAULT_N = fault_n_ff;
	assign GATE_OFF = gate_ff;

	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);

	a_clear_one_shot: assert property ( // (R1)
		wr_cal_clr && REG_WDATA[8] && !CAL_EVT.done |=> !pass_ff[2])
		else $error("phase A flag not cleared");
	a_clear_zero_keeps: assert property ( // (R2)
		wr_cal_clr && !REG_WDATA[4] && !CAL_EVT.done |=> $stable(pass_ff[1]))
		else $error("writing zero altered phase B flag");
	a_pass_sets: assert property ( // (R5)
		CAL_EVT.done && CAL_EVT.phase[0] |=> pass_ff[0] == $past(CAL_EVT.pass))
		else $error("phase C flag does not follow result");
	a_alarm_fault: assert property ( // (R7)
		alarm_ff |=> !FAULT_N && (GATE_OFF.all_off || GATE_OFF.motor_off))
		else $error("alarm did not force fault and shutdown");
	a_undef_kept: assert property ( // (R11)
		wr_qa && REG_WDATA[14:12] == 3'h7 |=> $stable(qa_rsp_ff))
		else $error("undefined response code was stored");
	a_start_capture: assert property ( // (R12)
		cmd_start |=> run_per_ff == $past(qa_per_ff) &&
			run_en_ff == $past(qa_en_ff))
		else $error("start did not capture control");
	a_bad_code_err: assert property ( // (R14)
		cmd_bad && qa_st_ff == caqt_pkg::QA_RUN && err_ff < 4'hE |=>
			err_ff > $past(err_ff))
		else $error("unassigned code did not count");
	a_stop_idles: assert property ( // (R13)
		cmd_stop |=> qa_st_ff == caqt_pkg::QA_IDLE)
		else $error("stop did not end sequence");
	a_read_status: assert property ( // (R3)
		REG_RD && REG_ADDR == `CAQT_RA_CAL_STAT |=>
			REG_RVALID && REG_RDATA[12] == $past(CAL_EVT.running))
		else $error("calibration activity misread");
	a_idle_no_err: assert property ( // (R18)
		qa_st_ff == caqt_pkg::QA_IDLE && !cmd_start |=> $stable(err_ff))
		else $error("error counted while idle");

endmodule : caqt_regs

// >>> dv/caqt_host.sv
/*
 Host side model: issues register writes, reads and answer commands.
 Assumes one caqt_regs on the same clock, one access per strobe.
*/
`timescale 1ns/1ps
`include "caqt_consts.svh"
module caqt_host (
	// Clock
	input wire logic clk,
	// Register access
	output logic wr,
	output logic rd,
	output logic [7:0] addr,
	output logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic rvalid
);
	initial
	begin
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
	end

	task automatic put(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1;
		wr = 1'b0;
		// Released lines show the inverse so no stale copy passes
		addr = ~a;
		wdata = ~d;
	endtask : put

	task automatic get(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		#1;
		rd = 1'b1;
		addr = a;
		@(posedge clk);
		#1;
		rd = 1'b0;
		addr = ~a;
		d = (rvalid === 1'b1) ? rdata : 16'hXXXX;
	endtask : get

	task automatic cmd(input logic [3:0] c, input logic [3:0] p);
		put(`CAQT_WA_ANSWER, {8'h00, c, p});
	endtask : cmd
endmodule : caqt_host

// >>> dv/tb.sv
/*
 Self-checking bench of the calibration, alarm and answer timer bank.
 Assumes small filter and timeout counts set at the instance below.
*/
`timescale 1ns/1ps
`include "caqt_consts.svh"
module tb;
	logic clk_sys;
	logic reset;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic reg_rvalid;
	logic alarm_in;
	logic fault_n;
	caqt_pkg::caqt_cal_evt_t cal_evt;
	caqt_pkg::caqt_gate_t gate_off;
	int bad_count;
	int samples_checked;
	int cycles;
	int fn [4] = '{2, 3, 4, 5};
	logic [15:0] r;

	caqt_regs #(.FIL_N0(2), .FIL_N1(3), .FIL_N2(4), .FIL_N3(5),
		.MS_TICKS(8)) caqt_regs_inst (
		.CLK_SYS(clk_sys), .RESET(reset), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
		.CAL_EVT(cal_evt), .ALARM_IN(alarm_in), .FAULT_N(fault_n),
		.GATE_OFF(gate_off));

	caqt_host caqt_host_inst (.clk(clk_sys), .wr(reg_wr), .rd(reg_rd),
		.addr(reg_addr), .wdata(reg_wdata), .rdata(reg_rdata),
		.rvalid(reg_rvalid));

	always #10 clk_sys = ~clk_sys;

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			summarize();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		caqt_host_inst.get(a, r);
		chk(r, exp);
	endtask : rchk

	task automatic qexp(input logic [3:0] e, s, p);
		rchk(`CAQT_RA_QA_COUNT, {4'h0, e, s, p});
	endtask : qexp

	task automatic ev(input logic [2:0] ph, input logic ok);
		@(posedge clk_sys);
		#1;
		cal_evt.done = 1'b1;
		cal_evt.pass = ok;
		cal_evt.phase = ph;
		@(posedge clk_sys);
		#1;
		cal_evt.done = 1'b0;
		cal_evt.phase = 3'h0;
	endtask : ev

	task automatic t_reset;
		chk({13'h0, gate_off}, 16'h0000);
		rchk(8'hC4, 16'h0000);
		rchk(8'hC8, 16'h0000);
		rchk(8'hCC, 16'h1000);
		rchk(8'hD0, 16'h000F);
		rchk(8'h90, 16'h0000);
		rchk(8'h48, 16'h0000);
	endtask : t_reset

	task automatic t_cal;
		cal_evt.running = 1'b1;
		rchk(8'hC4, 16'h1000);
		ev(3'b100, 1'b1);
		ev(3'b010, 1'b1);
		ev(3'b001, 1'b0);
		rchk(8'hC4, 16'h1110);
		ev(3'b001, 1'b1);
		ev(3'b100, 1'b0);
		cal_evt.running = 1'b0;
		rchk(8'hC4, 16'h0011);
		caqt_host_inst.put(8'h44, 16'hFEEE);
		rchk(8'hC4, 16'h0011);
		caqt_host_inst.put(8'h44, 16'h0010);
		rchk(8'hC4, 16'h0001);
		ev(3'b010, 1'b1);
		rchk(8'hC4, 16'h0011);
	endtask : t_cal

	task automatic t_alarm;
		int n;
		int k;
		logic [15:0] v;
		for (int i = 0; i < 4; i++)
		begin
			v = {3'h0, i[0], 10'h000, i[1:0]};
			caqt_host_inst.put(8'h48, v);
			rchk(8'hC8, v);
			alarm_in = 1'b1;
			n = 0;
			while (fault_n !== 1'b0 && n < 400)
			begin
				@(posedge clk_sys);
				#1;
				n++;
			end
			// Ticks are 12 or 13 clocks apart, so allow the spread
			k = 4 * fn[i] + 1;
			chk({15'h0, n >= (k - 1) * 25 / 2 - 3 && n <= k * 25 / 2 + 4},
				16'h0001);
			chk({13'h0, gate_off}, i[0] ? 16'h0002 : 16'h0004);
			alarm_in = 1'b0;
			repeat (3) @(posedge clk_sys);
			#1;
			chk({15'h0, fault_n}, 16'h0001);
		end
	endtask : t_alarm

	task automatic t_qctl;
		caqt_host_inst.put(8'h4C, 16'h2301);
		rchk(8'hCC, 16'h2301);
		caqt_host_inst.put(8'h4C, 16'h3101);
		rchk(8'hCC, 16'h3101);
		caqt_host_inst.put(8'h4C, 16'h7201);
		rchk(8'hCC, 16'h3201);
		caqt_host_inst.put(8'h4C, 16'h0000);
		rchk(8'hCC, 16'h3000);
	endtask : t_qctl

	task automatic t_qa;
		caqt_host_inst.cmd(4'hA, 4'h0);
		qexp(4'h0, 4'h0, 4'hF);
		caqt_host_inst.put(8'h4C, 16'h3001);
		caqt_host_inst.cmd(4'h7, 4'hF);
		qexp(4'h0, 4'h1, 4'hF);
		caqt_host_inst.cmd(4'h7, 4'hE);
		qexp(4'h0, 4'h2, 4'hE);
		caqt_host_inst.cmd(4'h7, 4'h0);
		qexp(4'h1, 4'h2, 4'hE);
		caqt_host_inst.cmd(4'h3, 4'h0);
		qexp(4'h2, 4'h2, 4'hE);
		repeat (150) @(posedge clk_sys);
		qexp(4'h2, 4'h2, 4'hE);
		caqt_host_inst.cmd(4'h5, 4'h0);
		for (int c = 0; c < 16; c++)
			if (c != 5 && c != 7 && c != 10)
				caqt_host_inst.cmd(c[3:0], 4'h0);
		qexp(4'h2, 4'h2, 4'hE);
		chk({15'h0, fault_n}, 16'h0001);
	endtask : t_qa

	task automatic t_trip;
		caqt_host_inst.put(8'h4C, 16'h4001);
		caqt_host_inst.cmd(4'hA, 4'h0);
		caqt_host_inst.put(8'h4C, 16'h1000);
		repeat (70) @(posedge clk_sys);
		qexp(4'h2, 4'h0, 4'hE);
		repeat (45) @(posedge clk_sys);
		qexp(4'h3, 4'h0, 4'hE);
		chk({15'h0, fault_n}, 16'h0001);
		repeat (100) @(posedge clk_sys);
		qexp(4'h4, 4'h0, 4'hE);
		chk({15'h0, fault_n}, 16'h0000);
		chk({13'h0, gate_off}, 16'h0005);
	endtask : t_trip

	// Trip is latched until reset, so each response code needs a fresh reset
	task automatic t_resp;
		for (int j = 1; j < 4; j++)
		begin
			@(posedge clk_sys);
			#1;
			reset = 1'b1;
			@(posedge clk_sys);
			#1;
			reset = 1'b0;
			chk({12'h0, fault_n, gate_off}, 16'h0008);
			caqt_host_inst.put(8'h4C, {1'b0, j[2:0], 12'h000});
			caqt_host_inst.cmd(4'hA, 4'h0);
			repeat (4) caqt_host_inst.cmd(4'h0, 4'h0);
			repeat (2) @(posedge clk_sys);
			#1;
			qexp(4'h4, 4'h0, 4'hF);
			chk({12'h0, fault_n, gate_off}, (j == 2) ? 16'h0004 :
				(j == 3) ? 16'h0002 : 16'h0000);
		end
	endtask : t_resp

	task automatic summarize;
		if (bad_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	initial
	begin
		clk_sys = 1'b0;
		reset = 1'b1;
		cal_evt = '0;
		alarm_in = 1'b0;
		bad_count = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (2) @(posedge clk_sys);
		#1;
		reset = 1'b0;
		t_reset();
		t_cal();
		t_alarm();
		t_qctl();
		t_qa();
		t_trip();
		t_resp();
		summarize();
	end
endmodule : tb
